//--- core/link_if.sv
// signals between the system-clock core and the link-clock side
// levels flow to the link, a byte toggle flows back; both come from flops
interface link_if;
	logic byte_toggle;
	logic send_on;
	logic recv_on;
	logic wait_on;
	modport core (input byte_toggle, output send_on, output recv_on, output wait_on);
	modport link (output byte_toggle, input send_on, input recv_on, input wait_on);
endinterface

//--- core/link_side.sv
// link-clock logic: turns byte pulses into a toggle, brings channel levels over
// assumes byte_done is a one-cycle pulse made on link_clock
module link_side (
	input  wire logic link_clock,
	input  wire logic nrst,
	input  wire logic byte_done,
	link_if.link      lk,
	output logic      send_active,
	output logic      recv_active,
	output logic      read_wait
);
	logic [2:0] lvl_sync;
	logic [2:0] lvl_pre;
	logic       toggle;
	logic       next_toggle;
	logic [2:0] next_lvl;

	// three stages; a level is taken over only once stages two and three agree
	sync_chain #(.STAGES(3), .WIDTH(3)) u_lvl (
		.clock (link_clock),
		.nrst  (nrst),
		.d     ({lk.wait_on, lk.recv_on, lk.send_on}),
		.q     (lvl_sync),
		.q_pre (lvl_pre)
	);

	always_comb begin
		// bytes only count while a wait state is shown to the card
		next_toggle = toggle ^ (byte_done & (send_active | recv_active));
		next_lvl[0] = (lvl_pre[0] == lvl_sync[0]) ? lvl_sync[0] : send_active;
		next_lvl[1] = (lvl_pre[1] == lvl_sync[1]) ? lvl_sync[1] : recv_active;
		next_lvl[2] = (lvl_pre[2] == lvl_sync[2]) ? lvl_sync[2] : read_wait;
	end

	always_ff @(posedge link_clock or negedge nrst) begin
		if (!nrst) begin
			toggle      <= 1'h0;
			send_active <= 1'h0;
			recv_active <= 1'h0;
			read_wait   <= 1'h0;
		end else begin
			toggle      <= next_toggle;
			send_active <= next_lvl[0];
			recv_active <= next_lvl[1];
			read_wait   <= next_lvl[2];
		end
	end

	assign lk.byte_toggle = toggle;
endmodule // link_side

//--- core/sd_data_path_control.sv
// data channel control: register port, channel state machine, byte counting
// assumes a card-side serialiser on link_clock pulses link_byte_done per byte
//
// Functional notes
// R1: block size code gives two-power byte length
// R2: bit 3 turns DMA servicing on
// R3: bit 2 set stream, clear block transfer
// R4: bit 1 set card to controller direction
// R5: go bit starts; direction picks wait state
// R6: read-wait start set enters read-wait state
// R7: go stays set; rewrite control per transfer
// R8: software spaces control writes seven clocks apart
// R9: codes 0 to 4 give 1 to 16 bytes
// R10: software sets timeout and length before start
// R11: block transfers use length multiple of block
// R12: counter loads length, counts down, ends idle
// R13: reserved block code starts no block transfer
module sd_data_path_control
	import sd_dpc_pkg::*;
(
	input  wire logic                          clock,
	input  wire logic                          nrst,
	input  wire logic                          link_clock,
	input  wire logic [sd_dpc_pkg::ADDR_W-1:0] address,
	input  wire logic [sd_dpc_pkg::DATA_W-1:0] write_data,
	input  wire logic                          write_strobe,
	input  wire logic                          read_strobe,
	output logic      [sd_dpc_pkg::DATA_W-1:0] read_data,
	input  wire logic                          link_byte_done,
	output logic                               dma_request,
	output logic                               link_send_active,
	output logic                               link_recv_active,
	output logic                               link_read_wait
);
	import sd_dpc_pkg::*;

	link_if lk ();

	logic [CTL_W-1:0]     control;
	logic [LEN_W-1:0]     length;
	logic [DATA_W-1:0]    timeout;
	logic [LEN_W-1:0]     count;
	logic [DATA_W-1:0]    tmo_count;
	logic [BLK_W-1:0]     blk_count;
	logic [FLAG_W-1:0]    flags;
	channel_state_e       state;
	logic                 tog_seen;
	logic                 send_lvl;
	logic                 recv_lvl;
	logic                 wait_lvl;

	logic [CTL_W-1:0]     next_control;
	logic [LEN_W-1:0]     next_length;
	logic [DATA_W-1:0]    next_timeout;
	logic [LEN_W-1:0]     next_count;
	logic [DATA_W-1:0]    next_tmo_count;
	logic [BLK_W-1:0]     next_blk_count;
	logic [FLAG_W-1:0]    next_flags;
	channel_state_e       next_state;
	logic                 next_tog_seen;
	logic                 next_send_lvl;
	logic                 next_recv_lvl;
	logic                 next_wait_lvl;
	logic                 next_dma_request;
	logic [DATA_W-1:0]    next_read_data;

	logic                 tog_s2;
	logic                 tog_s3;
	logic                 byte_evt;
	logic                 wr_ctl;
	logic                 wr_go;
	logic                 wr_bad_code;
	logic [3:0]           blk_code;
	logic [BLK_W-1:0]     blk_inc;

	// three stages; a toggle counts only once stages two and three agree
	sync_chain #(.STAGES(3), .WIDTH(1)) u_tog (
		.clock (clock),
		.nrst  (nrst),
		.d     (lk.byte_toggle),
		.q     (tog_s3),
		.q_pre (tog_s2)
	);

	link_side u_link (
		.link_clock  (link_clock),
		.nrst        (nrst),
		.byte_done   (link_byte_done),
		.lk          (lk.link),
		.send_active (link_send_active),
		.recv_active (link_recv_active),
		.read_wait   (link_read_wait)
	);

	assign lk.send_on = send_lvl;
	assign lk.recv_on = recv_lvl;
	assign lk.wait_on = wait_lvl;

	assign byte_evt = (tog_s2 == tog_s3) && (tog_s3 != tog_seen);
	assign wr_ctl   = write_strobe && (address == OFF_CONTROL);
	assign wr_go    = wr_ctl && write_data[CTL_GO];
	assign blk_code = control[CTL_BLK_LSB +: CTL_BLK_W];
	assign blk_inc  = BLK_W'(blk_count + 15'h0001);
	// stream transfers ignore the block size, so only block mode can be refused
	assign wr_bad_code = !write_data[CTL_MODE] &&
		(write_data[CTL_BLK_LSB +: CTL_BLK_W] == BLK_RESERVED); // [R13] [R3]

	always_comb begin
		next_control     = control;
		next_length      = length;
		next_timeout     = timeout;
		next_count       = count;
		next_tmo_count   = tmo_count;
		next_blk_count   = blk_count;
		next_flags       = flags;
		next_state       = state;
		next_tog_seen    = tog_s2 == tog_s3 ? tog_s3 : tog_seen;
		next_read_data   = '0;

		// register writes; go is never cleared by hardware
		if (wr_ctl) begin
			next_control = write_data[CTL_W-1:0]; // [R7]
		end
		if (write_strobe && (address == OFF_LENGTH)) begin
			next_length = write_data[LEN_W-1:0];
		end
		if (write_strobe && (address == OFF_TIMEOUT)) begin
			next_timeout = write_data;
		end
		// clear first so a flag raised in the same cycle survives
		if (write_strobe && (address == OFF_CLEAR)) begin
			next_flags = flags & ~write_data[FLAG_W-1:0];
		end

		case (state)
			CH_IDLE: begin
				if (wr_go && wr_bad_code) begin
					next_flags[ST_CFG_ERR] = 1'h1; // [R13]
				end else if (wr_go) begin
					next_count     = length; // [R12]
					next_tmo_count = timeout;
					next_blk_count = '0;
					if (write_data[CTL_RW_BEGIN]) begin
						next_state = CH_READ_WAIT; // [R6]
					end else if (write_data[CTL_DIR]) begin
						next_state = CH_WAIT_RECV; // [R5] [R4]
					end else begin
						next_state = CH_WAIT_SEND; // [R5] [R4]
					end
				end
			end
			CH_READ_WAIT: begin
				// held until software drops the start bit or sets the stop bit
				if (!control[CTL_RW_BEGIN] || control[CTL_RW_STOP]) begin
					next_state = control[CTL_DIR] ? CH_WAIT_RECV : CH_WAIT_SEND; // [R6]
				end
			end
			CH_WAIT_SEND, CH_WAIT_RECV: begin
				if (count == '0) begin
					next_state         = CH_IDLE; // [R12]
					next_flags[ST_END] = 1'h1; // [R12]
				end else if (byte_evt) begin
					next_count     = LEN_W'(count - 25'h0000001); // [R12]
					next_tmo_count = timeout;
					next_blk_count = blk_inc;
					if (!control[CTL_MODE] && (blk_inc == block_bytes(blk_code))) begin
						next_flags[ST_BLOCK] = 1'h1; // [R1] [R9] [R3]
						next_blk_count       = '0;
					end
				end else if (timeout != '0) begin
					// a zero timeout value disables the timer
					if (tmo_count == '0) begin
						next_state             = CH_IDLE;
						next_flags[ST_TIMEOUT] = 1'h1;
					end else begin
						next_tmo_count = DATA_W'(tmo_count - 32'h00000001);
					end
				end
			end
			default: begin
				next_state = CH_IDLE;
			end
		endcase

		next_send_lvl    = next_state == CH_WAIT_SEND;
		next_recv_lvl    = next_state == CH_WAIT_RECV;
		next_wait_lvl    = next_state == CH_READ_WAIT;
		next_dma_request = control[CTL_DMA] &&
			(state == CH_WAIT_SEND || state == CH_WAIT_RECV); // [R2]

		if (read_strobe) begin
			case (address)
				OFF_CONTROL: next_read_data = DATA_W'(control);
				OFF_LENGTH:  next_read_data = DATA_W'(length);
				OFF_TIMEOUT: next_read_data = timeout;
				OFF_COUNT:   next_read_data = DATA_W'(count);
				OFF_STATUS: begin
					next_read_data             = DATA_W'(flags);
					next_read_data[ST_SEND]    = state == CH_WAIT_SEND;
					next_read_data[ST_RECV]    = state == CH_WAIT_RECV;
					next_read_data[ST_RDWAIT]  = state == CH_READ_WAIT;
				end
				default:     next_read_data = '0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			control     <= CONTROL_RST;
			length      <= LENGTH_RST;
			timeout     <= TIMEOUT_RST;
			count       <= LENGTH_RST;
			tmo_count   <= TIMEOUT_RST;
			blk_count   <= '0;
			flags       <= '0;
			state       <= CH_IDLE;
			tog_seen    <= 1'h0;
			send_lvl    <= 1'h0;
			recv_lvl    <= 1'h0;
			wait_lvl    <= 1'h0;
			dma_request <= 1'h0;
			read_data   <= '0;
		end else begin
			control     <= next_control;
			length      <= next_length;
			timeout     <= next_timeout;
			count       <= next_count;
			tmo_count   <= next_tmo_count;
			blk_count   <= next_blk_count;
			flags       <= next_flags;
			state       <= next_state;
			tog_seen    <= next_tog_seen;
			send_lvl    <= next_send_lvl;
			recv_lvl    <= next_recv_lvl;
			wait_lvl    <= next_wait_lvl;
			dma_request <= next_dma_request;
			read_data   <= next_read_data;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	property p_start_send;
		(state == CH_IDLE && wr_go && !wr_bad_code && !write_data[CTL_DIR]
			&& !write_data[CTL_RW_BEGIN]) |=> state == CH_WAIT_SEND && send_lvl;
	endproperty
	a_start_send: assert property (p_start_send) else $error("no send wait after start"); // [R5]

	property p_start_recv;
		(state == CH_IDLE && wr_go && !wr_bad_code && write_data[CTL_DIR]
			&& !write_data[CTL_RW_BEGIN]) |=> state == CH_WAIT_RECV;
	endproperty
	a_start_recv: assert property (p_start_recv) else $error("no receive wait after start"); // [R4]

	property p_read_wait;
		(state == CH_IDLE && wr_go && !wr_bad_code && write_data[CTL_RW_BEGIN])
			|=> state == CH_READ_WAIT;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait not entered"); // [R6]

	property p_load;
		(state == CH_IDLE && wr_go && !wr_bad_code) |=> count == $past(length);
	endproperty
	a_load: assert property (p_load) else $error("counter not loaded"); // [R12]

	property p_end;
		((state == CH_WAIT_SEND || state == CH_WAIT_RECV) && count == '0)
			|=> state == CH_IDLE && flags[ST_END];
	endproperty
	a_end: assert property (p_end) else $error("no end at zero count"); // [R12]

	property p_dma;
		(control[CTL_DMA] && state == CH_WAIT_SEND) |=> dma_request;
	endproperty
	a_dma: assert property (p_dma) else $error("dma request missing"); // [R2]

	property p_no_dma;
		!control[CTL_DMA] |=> !dma_request;
	endproperty
	a_no_dma: assert property (p_no_dma) else $error("dma request while off"); // [R2]

	property p_reserved;
		(state == CH_IDLE && wr_go && wr_bad_code)
			|=> state == CH_IDLE && flags[ST_CFG_ERR] ##1 state == CH_IDLE;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code started"); // [R13]

	property p_go_kept;
		(state != CH_IDLE && !wr_ctl) |=> $stable(control);
	endproperty
	a_go_kept: assert property (p_go_kept) else $error("control changed by hardware"); // [R7]

	property p_stream_noblk;
		(control[CTL_MODE] && !flags[ST_BLOCK] && !wr_ctl) |=> !flags[ST_BLOCK];
	endproperty
	a_stream_noblk: assert property (p_stream_noblk) else $error("block flag in stream"); // [R3]

	// a whole block of bytes raises the block flag, for any defined code
	property p_block_done;
		((state == CH_WAIT_SEND || state == CH_WAIT_RECV) && count != '0 && byte_evt
			&& !control[CTL_MODE] && blk_code != BLK_RESERVED
			&& (32'(blk_count) + 32'h00000001) == (32'h00000001 << blk_code)) |=> flags[ST_BLOCK];
	endproperty
	a_block_done: assert property (p_block_done) else $error("block flag missed"); // [R1]

	property p_byte_block;
		((state == CH_WAIT_SEND || state == CH_WAIT_RECV) && count != '0 && byte_evt
			&& !control[CTL_MODE] && blk_code == 4'h0 && blk_count == '0) |=> flags[ST_BLOCK];
	endproperty
	a_byte_block: assert property (p_byte_block) else $error("unit block not flagged"); // [R9]

	property p_count_down;
		((state == CH_WAIT_SEND || state == CH_WAIT_RECV) && count != '0 && byte_evt)
			|=> count == $past(count) - 25'h0000001;
	endproperty
	a_count_down: assert property (p_count_down) else $error("count did not step"); // [R12]

	// a go written while busy must neither reload nor leave the wait state
	property p_busy_go;
		(state == CH_WAIT_SEND && wr_go && count != '0 && !byte_evt && timeout == '0)
			|=> state == CH_WAIT_SEND && count == $past(count);
	endproperty
	a_busy_go: assert property (p_busy_go) else $error("busy channel restarted"); // [R5]

	property p_idle_quiet;
		(state == CH_IDLE && !wr_go) |=> !send_lvl && !recv_lvl && !wait_lvl;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("link level without start"); // [R5]

	property p_rw_hold;
		(state == CH_READ_WAIT && control[CTL_RW_BEGIN] && !control[CTL_RW_STOP])
			|=> state == CH_READ_WAIT;
	endproperty
	a_rw_hold: assert property (p_rw_hold) else $error("read wait left early"); // [R6]

	property p_rw_leave;
		(state == CH_READ_WAIT && control[CTL_RW_STOP])
			|=> state == ($past(control[CTL_DIR]) ? CH_WAIT_RECV : CH_WAIT_SEND);
	endproperty
	a_rw_leave: assert property (p_rw_leave) else $error("wrong wait after read wait"); // [R4]

	property p_dma_recv;
		(control[CTL_DMA] && state == CH_WAIT_RECV) |=> dma_request;
	endproperty
	a_dma_recv: assert property (p_dma_recv) else $error("dma request missing on receive"); // [R2]
endmodule // sd_data_path_control

//--- core/sd_dpc_pkg.sv
// constants, state encoding and helpers for the data channel control block
// assumes a 32-bit register port with byte addresses on an 8-bit address
package sd_dpc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int LEN_W  = 25;
	localparam int CTL_W  = 12;
	localparam int FLAG_W = 4;
	localparam int BLK_W  = 15;

	// byte addresses
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_LENGTH  = 8'h04;
	localparam logic [7:0] OFF_TIMEOUT = 8'h08;
	localparam logic [7:0] OFF_COUNT   = 8'h0c;
	localparam logic [7:0] OFF_STATUS  = 8'h10;
	localparam logic [7:0] OFF_CLEAR   = 8'h14;

	// control field positions
	localparam int CTL_GO       = 0;
	localparam int CTL_DIR      = 1;
	localparam int CTL_MODE     = 2;
	localparam int CTL_DMA      = 3;
	localparam int CTL_BLK_LSB  = 4;
	localparam int CTL_BLK_W    = 4;
	localparam int CTL_RW_BEGIN = 8;
	localparam int CTL_RW_STOP  = 9;
	localparam int CTL_RW_MODE  = 10;
	localparam int CTL_IO_EN    = 11;

	// status field positions (flags sticky, the rest live)
	localparam int ST_END     = 0;
	localparam int ST_TIMEOUT = 1;
	localparam int ST_BLOCK   = 2;
	localparam int ST_CFG_ERR = 3;
	localparam int ST_SEND    = 4;
	localparam int ST_RECV    = 5;
	localparam int ST_RDWAIT  = 6;

	localparam logic [CTL_W-1:0]  CONTROL_RST = 12'h000;
	localparam logic [LEN_W-1:0]  LENGTH_RST  = 25'h0000000;
	localparam logic [DATA_W-1:0] TIMEOUT_RST = 32'h00000000;
	localparam logic [3:0]        BLK_RESERVED = 4'hf;

	// least system clocks between two control writes, kept by software
	localparam int CTRL_WRITE_GAP = 7;

	typedef enum logic [3:0] {
		CH_IDLE      = 4'b0001,
		CH_WAIT_SEND = 4'b0010,
		CH_WAIT_RECV = 4'b0100,
		CH_READ_WAIT = 4'b1000
	} channel_state_e;

	function automatic logic [BLK_W-1:0] block_bytes(input logic [3:0] code);
		block_bytes = BLK_W'(15'h0001 << code);
	endfunction
endpackage

//--- core/sync_chain.sv
// flop chain synchroniser; q is the last stage, q_pre the one before it
// assumes d is a level or a toggle from another clock domain
module sync_chain #(
	parameter int STAGES = 2,
	parameter int WIDTH  = 1
) (
	input  wire logic             clock,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q,
	output logic      [WIDTH-1:0] q_pre
);
	logic [WIDTH-1:0] chain      [STAGES];
	logic [WIDTH-1:0] next_chain [STAGES];

	always_comb begin
		next_chain[0] = d;
		for (int i = 1; i < STAGES; i++) begin
			next_chain[i] = chain[i-1];
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < STAGES; i++) begin
				chain[i] <= '0;
			end
		end else begin
			chain <= next_chain;
		end
	end

	assign q     = chain[STAGES-1];
	assign q_pre = chain[STAGES-2];
endmodule // sync_chain

//--- verif/card_model.sv
// card-side model: paces byte pulses on the link clock while a wait state is shown
// assumes the link levels arrive already registered in the link_clock domain
module card_model (
	input  wire logic link_clock,
	input  wire logic nrst,
	input  wire logic send_active,
	input  wire logic recv_active,
	input  wire logic slow,
	output logic      byte_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] gap;
	// pulses kept two or five link clocks apart so the toggle crossing never merges two
	always @(posedge link_clock or negedge nrst) begin
		if (!nrst) begin
			gap       <= 3'h0;
			byte_done <= 1'b0;
		end else if ((send_active || recv_active) && gap == 3'h0) begin
			byte_done <= 1'b1;
			gap       <= slow ? 3'h4 : 3'h1;
		end else begin
			byte_done <= 1'b0;
			if (gap != 3'h0) begin
				gap <= gap - 3'h1;
			end
		end
	end
endmodule // card_model

//--- verif/tb.sv
// self-checking bench for the data channel control block
// assumes the card model on the link side and read notes checked by a monitor
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sd_dpc_pkg::*;
	typedef struct {
		string              name;
		logic [DATA_W-1:0] exp;
	} note_s;
	localparam logic [31:0] T_CTL [3]  = '{32'h00000011, 32'h0000001f, 32'h0000002b};
	localparam logic [24:0] T_LEN [3]  = '{25'h0000004, 25'h0000005, 25'h0000008};
	localparam logic [31:0] T_LIVE [3] = '{32'h00000010, 32'h00000020, 32'h00000020};
	localparam logic [31:0] T_END [3]  = '{32'h00000005, 32'h00000001, 32'h00000005};
	logic              clock;
	logic              nrst;
	logic              link_clock;
	logic [ADDR_W-1:0] address;
	logic [DATA_W-1:0] write_data;
	logic              write_strobe;
	logic              read_strobe;
	logic [DATA_W-1:0] read_data;
	logic              link_byte_done;
	logic              dma_request;
	logic              link_send_active;
	logic              link_recv_active;
	logic              link_read_wait;
	logic              card_slow;
	logic              rd_seen;
	logic [31:0]       seed;
	int                error_cnt;
	int                checks_done;
	int                cycles;
	note_s             notes[$];

	sd_data_path_control i_dut (.clock(clock), .nrst(nrst), .link_clock(link_clock),
		.address(address), .write_data(write_data), .write_strobe(write_strobe),
		.read_strobe(read_strobe), .read_data(read_data), .link_byte_done(link_byte_done),
		.dma_request(dma_request), .link_send_active(link_send_active),
		.link_recv_active(link_recv_active), .link_read_wait(link_read_wait));
	card_model i_card (.link_clock(link_clock), .nrst(nrst), .send_active(link_send_active),
		.recv_active(link_recv_active), .slow(card_slow), .byte_done(link_byte_done));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// phase offset keeps the two domains unrelated
	initial begin
		link_clock = 1'b0;
		#37;
		forever #80 link_clock = ~link_clock;
	end

	function logic [31:0] next_rand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check_word(string name, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic check_bit(string name, logic exp, logic got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, got);
		end
	endtask
	task stop_test();
		$display("comparisons %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic bus(logic we, logic re, logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		write_strobe <= we;
		read_strobe  <= re;
		address      <= a;
		write_data   <= d;
		@(posedge clock);
		write_strobe <= 1'b0;
		read_strobe  <= 1'b0;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(string name, logic [7:0] a, logic [31:0] exp);
		notes.push_back('{name, exp});
		bus(1'b0, 1'b1, a, 32'h00000000);
	endtask

	// read data stand only in the cycle after the strobe, so they are taken at the next edge
	always @(posedge clock) begin : monitor
		note_s n;
		cycles++;
		if (cycles > 20000) begin
			error_cnt++;
			stop_test();
		end else begin
			if (rd_seen) begin
				n = notes.pop_front();
				check_word(n.name, n.exp, read_data);
			end
			rd_seen <= read_strobe && nrst;
		end
	end

	task automatic start(logic [31:0] ctl, logic [24:0] len, logic [31:0] live);
		wr(OFF_CLEAR, 32'h0000000f);
		wr(OFF_TIMEOUT, 32'h00000000);
		wr(OFF_LENGTH, {7'h00, len});
		wr(OFF_CONTROL, ctl);
		rd("status live", OFF_STATUS, live);
		rd("count load", OFF_COUNT, {7'h00, len});
		check_bit("dma_request", ctl[CTL_DMA], dma_request);
	endtask
	task automatic finish(string name, logic [31:0] ctl, logic [31:0] status);
		int i;
		i = 0;
		while (link_send_active !== 1'b1 && link_recv_active !== 1'b1 && i < 300) begin
			@(posedge clock);
			i++;
		end
		check_bit("link recv level", ctl[CTL_DIR], link_recv_active);
		check_bit("link send level", ~ctl[CTL_DIR], link_send_active);
		i = 0;
		while ((link_send_active !== 1'b0 || link_recv_active !== 1'b0) && i < 3000) begin
			@(posedge clock);
			i++;
		end
		check_bit("link idle", 1'b0, link_send_active | link_recv_active);
		repeat (4) @(posedge clock);
		rd("status end", OFF_STATUS, status);
		rd("count end", OFF_COUNT, 32'h00000000);
		rd("control kept", OFF_CONTROL, ctl);
		repeat (CTRL_WRITE_GAP) @(posedge clock);
		$display("test %s done", name);
	endtask

	initial begin : main
		logic [31:0] w;
		int          i;
		nrst         = 1'b0;
		address      = 8'h00;
		write_data   = 32'h00000000;
		write_strobe = 1'b0;
		read_strobe  = 1'b0;
		card_slow    = 1'b0;
		rd_seen      = 1'b0;
		seed         = 32'h0001146b;
		error_cnt    = 0;
		checks_done  = 0;
		cycles       = 0;
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		for (i = 0; i < 7; i++) begin
			rd("reset value", 8'(i * 4), 32'h00000000); // unmapped at the last step
		end
		wr(OFF_LENGTH, 32'hffffffff);
		rd("length width", OFF_LENGTH, 32'h01ffffff);
		w = next_rand();
		wr(OFF_TIMEOUT, w);
		rd("timeout rw", OFF_TIMEOUT, w);
		wr(OFF_COUNT, 32'h00001234);
		rd("count read only", OFF_COUNT, 32'h00000000);
		$display("test registers done");
		for (i = 0; i < 16; i++) begin
			w = (next_rand() & 32'hffffff0e) | (32'(i) << CTL_BLK_LSB);
			wr(OFF_CONTROL, w);
			rd("control fields", OFF_CONTROL, w & 32'h00000fff);
			repeat (CTRL_WRITE_GAP) @(posedge clock);
		end
		$display("test control fields done");
		for (i = 0; i < 3; i++) begin
			card_slow <= i[0];
			start(T_CTL[i], T_LEN[i], T_LIVE[i]);
			finish("transfer", T_CTL[i], T_END[i]);
		end
		start(32'h00000103, 25'h0000002, 32'h00000040);
		i = 0;
		while (link_read_wait !== 1'b1 && i < 300) begin
			@(posedge clock);
			i++;
		end
		check_bit("read wait level", 1'b1, link_read_wait);
		check_bit("no recv in read wait", 1'b0, link_recv_active);
		repeat (CTRL_WRITE_GAP) @(posedge clock);
		wr(OFF_CONTROL, 32'h00000303);
		rd("read wait left", OFF_STATUS, 32'h00000020);
		finish("read wait", 32'h00000303, 32'h00000005);
		wr(OFF_CLEAR, 32'h0000000f);
		wr(OFF_CONTROL, 32'h000000f1);
		rd("reserved code", OFF_STATUS, 32'h00000008);
		repeat (60) @(posedge clock);
		check_bit("no link start", 1'b0, link_send_active | link_recv_active);
		wr(OFF_CLEAR, 32'h0000000f);
		rd("flags cleared", OFF_STATUS, 32'h00000000);
		repeat (4) @(posedge clock);
		$display("test reserved code done");
		wr(OFF_TIMEOUT, 32'h00000008);
		wr(OFF_LENGTH, 32'h00000004);
		wr(OFF_CONTROL, 32'h00000011);
		repeat (40) @(posedge clock);
		rd("timeout flag", OFF_STATUS, 32'h00000002);
		rd("count held", OFF_COUNT, 32'h00000004);
		repeat (2) @(posedge clock);
		$display("test timeout done");
		stop_test();
	end
endmodule // tb
